//--- src/spf_pkg.sv
/*
  Constants and carrier types for the shared pin function select block.
  Assumes a single pclk domain and an APB register interface.
*/
`default_nettype none
package spf_pkg;

  // ==========================================================
  // register map (byte addresses, one word each)
  localparam int SPF_ADDR_W = 8;
  localparam int SPF_REG_W = 16;
  localparam logic [7:0] SPF_OFF_MUX = 8'h00;
  localparam logic [7:0] SPF_OFF_DIR_A = 8'h04;
  localparam logic [7:0] SPF_OFF_DIR_B = 8'h08;
  localparam logic [7:0] SPF_OFF_IRQ1 = 8'h0C;
  localparam logic [7:0] SPF_OFF_IRQ2 = 8'h10;
  localparam logic [7:0] SPF_OFF_ADC2 = 8'h14;
  localparam logic [7:0] SPF_OFF_CAP = 8'h18;
  localparam logic [7:0] SPF_OFF_PIN = 8'h1C;

  // ==========================================================
  // field positions
  localparam int SPF_MUX_CMP5_BIT = 5;
  localparam int SPF_MUX_CMP6_BIT = 6;
  localparam int SPF_MUX_CLK_BIT = 7;
  localparam int SPF_MUX_T2_BIT = 8;
  localparam int SPF_DIR_SHIFT = 8;
  localparam int SPF_PA5_BIT = 5;
  localparam int SPF_PA6_BIT = 6;
  localparam int SPF_PA7_BIT = 7;
  localparam int SPF_PB0_BIT = 0;
  localparam int SPF_EN_BIT = 0;
  localparam int SPF_FLAG_BIT = 15;
  localparam int SPF_CAP_EN_BIT = 15;
  localparam int SPF_CAP_EDGE_LO = 4;
  localparam int SPF_CAP_EDGE_HI = 5;
  localparam logic [15:0] SPF_RESET_WORD = 16'h0000;

  // ==========================================================
  // pin indices
  localparam int SPF_NUM_PINS = 4;
  localparam int SPF_PIN_CMP5 = 0;
  localparam int SPF_PIN_CMP6 = 1;
  localparam int SPF_PIN_T2 = 2;
  localparam int SPF_PIN_X2 = 3;

  // per-pad drive request
  typedef struct packed {
    logic dedicated;
    logic ded_value;
    logic dir_out;
    logic gpio_data;
  } spf_pad_type;

endpackage : spf_pkg
`default_nettype wire

//--- src/spf_pad_cell.sv
/*
  One pad driver: picks the dedicated output or the gpio bit.
  Assumes the request is stable per pclk cycle; pad wire resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
module spf_pad_cell
  import spf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire spf_pad_type req,
  output logic pad_out,
  output logic pad_oe_n
);

  // ==========================================================
  // registered driver, dedicated output overrides direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end else if (req.dedicated) begin
      pad_out <= req.ded_value;
      pad_oe_n <= 1'b0;
    end else begin
      pad_out <= req.gpio_data;
      pad_oe_n <= ~req.dir_out;
    end
  end

endmodule // spf_pad_cell
`default_nettype wire

//--- src/spf_pin_mux.sv
/*
  Function select for four shared pins, configured over APB.
  Assumes pad inputs synchronous to pclk and peripheral signals on pclk.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// - each compare pin carries either its compare output or its gpio bit.
// - after reset the timer-2 pin is interrupt one or gpio, never pwm.
// - interrupt one reaches its logic only while its enable bit is set.
// - writing 1 to mux bit 8 drives the timer-2 pwm onto its pin.
// - interrupt one detection depends only on its own control register.
// - all four pins read as gpio inputs with no setup.
// - a pin drives as gpio output only once its direction bit says so.
// - the fourth pin can take several roles at a time after reset.
// - interrupt two uses the pin only while its enable bit is set.
// - the adc start trigger is taken only while its enable bit is set.
// - capture one uses the pin only while capture is configured.
// - writing 1 to mux bit 7 puts the cpu clock on the fourth pin.
// - with clock output selected, the fourth pin's inputs all see a constant 1.
module spf_pin_mux
  import spf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SPF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic compare_out_five,
  input wire logic compare_out_six,
  input wire logic timer2_pwm_out,
  input wire logic cpu_clock_output,
  input wire logic [SPF_NUM_PINS-1:0] pad_in,
  output logic [SPF_NUM_PINS-1:0] pad_out,
  output logic [SPF_NUM_PINS-1:0] pad_oe_n,
  output logic ext_irq_one,
  output logic ext_irq_two,
  output logic adc_start_trigger,
  output logic capture_in_one
);

  // ==========================================================
  // register state
  logic [SPF_REG_W-1:0] pin_mux_control_a;
  logic [SPF_REG_W-1:0] port_a_data_direction;
  logic [SPF_REG_W-1:0] port_b_data_direction;
  logic [SPF_REG_W-1:0] ext_irq_one_control;
  logic [SPF_REG_W-1:0] ext_irq_two_control;
  logic [SPF_REG_W-1:0] adc_control_two;
  logic [SPF_REG_W-1:0] capture_control;
  logic [SPF_NUM_PINS-1:0] pin_status;
  logic irq_one_flag;
  logic irq_two_flag;
  logic wr_en;
  logic rd_hit;
  logic [SPF_REG_W-1:0] next_rdata;
  logic sel_clk;
  logic irq_one_en;
  logic irq_two_en;
  logic soc_en;
  logic cap_en;
  logic next_irq_one;
  logic next_irq_two;
  logic next_soc;
  logic next_cap;
  logic first_cycle;
  spf_pad_type pad_req [SPF_NUM_PINS];

  // decode of a word address to a hit
  function automatic logic addr_hit(input logic [SPF_ADDR_W-1:0] a);
    unique case (a)
      SPF_OFF_MUX, SPF_OFF_DIR_A, SPF_OFF_DIR_B, SPF_OFF_IRQ1,
      SPF_OFF_IRQ2, SPF_OFF_ADC2, SPF_OFF_CAP, SPF_OFF_PIN: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_hit = addr_hit(paddr);
  assign pslverr = psel & penable & ~rd_hit;

  // write path for control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mux_control_a <= SPF_RESET_WORD;
      port_a_data_direction <= SPF_RESET_WORD;
      port_b_data_direction <= SPF_RESET_WORD;
      ext_irq_one_control <= SPF_RESET_WORD;
      ext_irq_two_control <= SPF_RESET_WORD;
      adc_control_two <= SPF_RESET_WORD;
      capture_control <= SPF_RESET_WORD;
    end else if (wr_en) begin
      unique case (paddr)
        SPF_OFF_MUX: pin_mux_control_a <= pwdata[SPF_REG_W-1:0];
        SPF_OFF_DIR_A: port_a_data_direction <= pwdata[SPF_REG_W-1:0];
        SPF_OFF_DIR_B: port_b_data_direction <= pwdata[SPF_REG_W-1:0];
        SPF_OFF_IRQ1: ext_irq_one_control <= pwdata[SPF_REG_W-1:0];
        SPF_OFF_IRQ2: ext_irq_two_control <= pwdata[SPF_REG_W-1:0];
        SPF_OFF_ADC2: adc_control_two <= pwdata[SPF_REG_W-1:0];
        SPF_OFF_CAP: capture_control <= pwdata[SPF_REG_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux, flags show in bit 15 of the interrupt words
  always_comb begin
    next_rdata = SPF_RESET_WORD;
    unique case (paddr)
      SPF_OFF_MUX: next_rdata = pin_mux_control_a;
      SPF_OFF_DIR_A: next_rdata = port_a_data_direction;
      SPF_OFF_DIR_B: next_rdata = port_b_data_direction;
      SPF_OFF_IRQ1: begin
        next_rdata = ext_irq_one_control;
        next_rdata[SPF_FLAG_BIT] = irq_one_flag;
      end
      SPF_OFF_IRQ2: begin
        next_rdata = ext_irq_two_control;
        next_rdata[SPF_FLAG_BIT] = irq_two_flag;
      end
      SPF_OFF_ADC2: next_rdata = adc_control_two;
      SPF_OFF_CAP: next_rdata = capture_control;
      SPF_OFF_PIN: next_rdata = {{(SPF_REG_W-SPF_NUM_PINS){1'b0}},
                                 pin_status};
      default: next_rdata = SPF_RESET_WORD;
    endcase
  end
  assign prdata = {16'h0000, next_rdata};

  // ==========================================================
  // pad drive requests
  assign sel_clk = pin_mux_control_a[SPF_MUX_CLK_BIT];

  // compare pins: compare output or port a gpio
  assign pad_req[SPF_PIN_CMP5] = '{
    dedicated: pin_mux_control_a[SPF_MUX_CMP5_BIT],
    ded_value: compare_out_five,
    dir_out: port_a_data_direction[SPF_PA5_BIT + SPF_DIR_SHIFT],
    gpio_data: port_a_data_direction[SPF_PA5_BIT]};
  assign pad_req[SPF_PIN_CMP6] = '{
    dedicated: pin_mux_control_a[SPF_MUX_CMP6_BIT],
    ded_value: compare_out_six,
    dir_out: port_a_data_direction[SPF_PA6_BIT + SPF_DIR_SHIFT],
    gpio_data: port_a_data_direction[SPF_PA6_BIT]};

  // timer-2 pin: pwm when mux bit 8 set, else port b bit zero
  assign pad_req[SPF_PIN_T2] = '{
    dedicated: pin_mux_control_a[SPF_MUX_T2_BIT],
    ded_value: timer2_pwm_out,
    dir_out: port_b_data_direction[SPF_PB0_BIT + SPF_DIR_SHIFT],
    gpio_data: port_b_data_direction[SPF_PB0_BIT]};

  // fourth pin: cpu clock when mux bit 7 set, else port a bit seven
  assign pad_req[SPF_PIN_X2] = '{
    dedicated: sel_clk,
    ded_value: cpu_clock_output,
    dir_out: port_a_data_direction[SPF_PA7_BIT + SPF_DIR_SHIFT],
    gpio_data: port_a_data_direction[SPF_PA7_BIT]};

  // one driver per pin
  for (genvar g = 0; g < SPF_NUM_PINS; g++) begin : g_pad
    spf_pad_cell u_pad (
      .pclk(pclk),
      .presetn(presetn),
      .req(pad_req[g]),
      .pad_out(pad_out[g]),
      .pad_oe_n(pad_oe_n[g])
    );
  end

  // ==========================================================
  // input routing to peripherals, idle level is high
  assign irq_one_en = ext_irq_one_control[SPF_EN_BIT];
  assign irq_two_en = ext_irq_two_control[SPF_EN_BIT];
  assign soc_en = adc_control_two[SPF_EN_BIT];
  assign cap_en = capture_control[SPF_CAP_EN_BIT] &
                  (|capture_control[SPF_CAP_EDGE_HI:SPF_CAP_EDGE_LO]);

  // gating of each role; clock output forces the fourth-pin roles to 1
  always_comb begin
    next_irq_one = irq_one_en ? pad_in[SPF_PIN_T2] : 1'b1;
    next_irq_two = 1'b1;
    next_soc = 1'b1;
    next_cap = 1'b1;
    if (!sel_clk) begin
      next_irq_two = irq_two_en ? pad_in[SPF_PIN_X2] : 1'b1;
      next_soc = soc_en ? pad_in[SPF_PIN_X2] : 1'b1;
      next_cap = cap_en ? pad_in[SPF_PIN_X2] : 1'b1;
    end
  end

  // registered peripheral inputs and raw pin status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_one <= 1'b1;
      ext_irq_two <= 1'b1;
      adc_start_trigger <= 1'b1;
      capture_in_one <= 1'b1;
      pin_status <= '0;
    end else begin
      ext_irq_one <= next_irq_one;
      ext_irq_two <= next_irq_two;
      adc_start_trigger <= next_soc;
      capture_in_one <= next_cap;
      pin_status <= pad_in;
    end
  end

  // falling-edge flags, write 1 clears, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_one_flag <= 1'b0;
      irq_two_flag <= 1'b0;
    end else begin
      if (ext_irq_one && !next_irq_one)
        irq_one_flag <= 1'b1;
      else if (wr_en && paddr == SPF_OFF_IRQ1 && pwdata[SPF_FLAG_BIT])
        irq_one_flag <= 1'b0;
      if (ext_irq_two && !next_irq_two)
        irq_two_flag <= 1'b1;
      else if (wr_en && paddr == SPF_OFF_IRQ2 && pwdata[SPF_FLAG_BIT])
        irq_two_flag <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      first_cycle <= 1'b1;
    else
      first_cycle <= 1'b0;
  end

  property p_cmp_five;
    @(posedge pclk) disable iff (!presetn)
    pin_mux_control_a[SPF_MUX_CMP5_BIT] |=>
      !pad_oe_n[SPF_PIN_CMP5] &&
      pad_out[SPF_PIN_CMP5] == $past(compare_out_five);
  endproperty
  a_cmp_five: assert property (p_cmp_five)
    else $error("compare five not on its pin");

  property p_reset_role;
    @(posedge pclk) disable iff (!presetn)
    first_cycle |-> pad_oe_n[SPF_PIN_T2] &&
      !pin_mux_control_a[SPF_MUX_T2_BIT];
  endproperty
  a_reset_role: assert property (p_reset_role)
    else $error("timer-2 pin driven right after reset");

  property p_irq_one_off;
    @(posedge pclk) disable iff (!presetn)
    !irq_one_en |=> ext_irq_one;
  endproperty
  a_irq_one_off: assert property (p_irq_one_off)
    else $error("interrupt one passed while disabled");

  property p_irq_one_mux_free;
    @(posedge pclk) disable iff (!presetn)
    irq_one_en |=> ext_irq_one == $past(pad_in[SPF_PIN_T2]);
  endproperty
  a_irq_one_mux_free: assert property (p_irq_one_mux_free)
    else $error("interrupt one not following pin");

  property p_t2_drive;
    @(posedge pclk) disable iff (!presetn)
    pin_mux_control_a[SPF_MUX_T2_BIT] |=> !pad_oe_n[SPF_PIN_T2] &&
      pad_out[SPF_PIN_T2] == $past(timer2_pwm_out);
  endproperty
  a_t2_drive: assert property (p_t2_drive)
    else $error("timer-2 pwm not driven");

  property p_pin_status;
    @(posedge pclk) disable iff (!presetn)
    !first_cycle |=> pin_status == $past(pad_in);
  endproperty
  a_pin_status: assert property (p_pin_status)
    else $error("pin status not tracking pads");

  property p_gpio_input;
    @(posedge pclk) disable iff (!presetn)
    !sel_clk && !port_a_data_direction[SPF_PA7_BIT + SPF_DIR_SHIFT]
      |=> pad_oe_n[SPF_PIN_X2];
  endproperty
  a_gpio_input: assert property (p_gpio_input)
    else $error("fourth pin driven as input");

  property p_irq_two_gate;
    @(posedge pclk) disable iff (!presetn)
    !sel_clk && irq_two_en |=> ext_irq_two == $past(pad_in[SPF_PIN_X2]);
  endproperty
  a_irq_two_gate: assert property (p_irq_two_gate)
    else $error("interrupt two not following pin");

  property p_soc_gate;
    @(posedge pclk) disable iff (!presetn)
    !soc_en |=> adc_start_trigger;
  endproperty
  a_soc_gate: assert property (p_soc_gate)
    else $error("adc trigger passed while disabled");

  property p_cap_gate;
    @(posedge pclk) disable iff (!presetn)
    !cap_en |=> capture_in_one;
  endproperty
  a_cap_gate: assert property (p_cap_gate)
    else $error("capture passed while unconfigured");

  property p_clk_out;
    @(posedge pclk) disable iff (!presetn)
    sel_clk |=> !pad_oe_n[SPF_PIN_X2] &&
      pad_out[SPF_PIN_X2] == $past(cpu_clock_output);
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("clock not on fourth pin");

  property p_clk_forces_one;
    @(posedge pclk) disable iff (!presetn)
    sel_clk |=> ext_irq_two && adc_start_trigger && capture_in_one;
  endproperty
  a_clk_forces_one: assert property (p_clk_forces_one)
    else $error("inputs not forced high under clock output");

  property p_override;
    @(posedge pclk) disable iff (!presetn)
    pin_mux_control_a[SPF_MUX_CMP6_BIT] &&
      !port_a_data_direction[SPF_PA6_BIT + SPF_DIR_SHIFT]
      |=> !pad_oe_n[SPF_PIN_CMP6];
  endproperty
  a_override: assert property (p_override)
    else $error("dedicated output lost to direction bit");

endmodule // spf_pin_mux
`default_nettype wire

//--- dv/spf_pin_mux_tb_top.sv
/*
  Self-checking bench for the shared pin function select block.
  Assumes the design package and top module compile first; one pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module spf_pin_mux_tb_top
  import spf_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite;
  logic [SPF_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic compare_out_five, compare_out_six, timer2_pwm_out, cpu_clock_output;
  logic [SPF_NUM_PINS-1:0] pad_in, pad_out, pad_oe_n;
  logic ext_irq_one, ext_irq_two, adc_start_trigger, capture_in_one;
  logic [3:0] periph;
  logic [7:0] roff [0:2];
  logic [31:0] rval [0:2];
  int err_total = 0;
  int checks = 0;

  assign periph = {ext_irq_one, ext_irq_two, adc_start_trigger, capture_in_one};

  spf_pin_mux dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_out_five(compare_out_five), .compare_out_six(compare_out_six),
    .timer2_pwm_out(timer2_pwm_out), .cpu_clock_output(cpu_clock_output),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .ext_irq_one(ext_irq_one), .ext_irq_two(ext_irq_two),
    .adc_start_trigger(adc_start_trigger), .capture_in_one(capture_in_one));

  // ==========================================================
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_sim();
  end

  // ==========================================================
  // shared tasks
  task automatic end_sim();
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic is_wr, input logic [SPF_ADDR_W-1:0] addr,
                     input logic [31:0] wd, output logic [31:0] rdat,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [SPF_ADDR_W-1:0] addr, input logic [31:0] d);
    logic [31:0] rdat;
    logic err;
    apb(1'b1, addr, d, rdat, err);
  endtask

  task automatic rd(input logic [SPF_ADDR_W-1:0] addr, input logic [31:0] exp,
                    input logic exp_err);
    logic [31:0] r;
    logic err;
    apb(1'b0, addr, 32'h0, r, err);
    chk("prdata", r, exp);
    chk("pslverr", {31'h0, err}, {31'h0, exp_err});
  endtask

  // pads settle one edge after a register lands; checked after three
  task automatic pads(input logic [3:0] oe, input logic [3:0] mask,
                      input logic [3:0] val);
    step(3);
    chk("pad_oe_n", {28'h0, pad_oe_n}, {28'h0, oe});
    chk("pad_out", {28'h0, pad_out & mask}, {28'h0, val});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    compare_out_five = 1'b0;
    compare_out_six = 1'b0;
    timer2_pwm_out = 1'b1;
    cpu_clock_output = 1'b0;
    pad_in = 4'hF;
    roff[0] = SPF_OFF_IRQ2;
    roff[1] = SPF_OFF_ADC2;
    roff[2] = SPF_OFF_CAP;
    rval[0] = 32'h0000_0001;
    rval[1] = 32'h0000_0001;
    rval[2] = 32'h0000_8010;
    step(12);
    presetn <= 1'b1;
    // reset state, timer-2 pin not driven as pwm
    pads(4'hF, 4'hF, 4'h0);
    chk("periph", {28'h0, periph}, 32'hF);
    rd(SPF_OFF_MUX, 32'h0, 1'b0);
    rd(SPF_OFF_IRQ1, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    // pins read as inputs with no setup; status is read only
    pad_in <= 4'hA;
    step(3);
    rd(SPF_OFF_PIN, 32'h0000_000A, 1'b0);
    wr(SPF_OFF_PIN, 32'h0000_000F);
    rd(SPF_OFF_PIN, 32'h0000_000A, 1'b0);
    pad_in <= 4'hF;
    // compare pins: gpio output, then compare output overriding gpio
    wr(SPF_OFF_DIR_A, 32'h0000_6020);
    pads(4'hC, 4'h3, 4'h1);
    compare_out_six <= 1'b1;
    wr(SPF_OFF_MUX, 32'h0000_0060);
    pads(4'hC, 4'h3, 4'h2);
    wr(SPF_OFF_DIR_A, 32'h0);
    pads(4'hC, 4'h3, 4'h2);
    wr(SPF_OFF_MUX, 32'h0);
    pads(4'hF, 4'h0, 4'h0);
    // timer-2 pin: port b output, then pwm overriding it
    wr(SPF_OFF_DIR_B, 32'h0000_0101);
    pads(4'hB, 4'h4, 4'h4);
    timer2_pwm_out <= 1'b0;
    wr(SPF_OFF_MUX, 32'h0000_0100);
    pads(4'hB, 4'h4, 4'h0);
    wr(SPF_OFF_DIR_B, 32'h0);
    pads(4'hB, 4'h4, 4'h0);
    // interrupt one gated only by its own enable
    pad_in <= 4'hB;
    step(3);
    chk("periph", {28'h0, periph}, 32'hF);
    pad_in <= 4'hF;
    wr(SPF_OFF_IRQ1, 32'h0000_0001);
    pad_in <= 4'hB;
    step(3);
    chk("periph", {28'h0, periph}, 32'h7);
    rd(SPF_OFF_IRQ1, 32'h0000_8001, 1'b0);
    wr(SPF_OFF_IRQ1, 32'h0000_8001);
    rd(SPF_OFF_IRQ1, 32'h0000_0001, 1'b0);
    wr(SPF_OFF_MUX, 32'h0);
    step(3);
    chk("periph", {28'h0, periph}, 32'h7);
    wr(SPF_OFF_IRQ1, 32'h0);
    step(3);
    chk("periph", {28'h0, periph}, 32'hF);
    pad_in <= 4'hF;
    // fourth pin: each role alone, only when enabled
    for (int i = 0; i < 3; i++) begin
      wr(roff[i], rval[i]);
      pad_in <= 4'h7;
      step(3);
      chk("periph", {28'h0, periph}, 32'hF ^ (32'h4 >> i));
      pad_in <= 4'hF;
      step(3);
      wr(roff[i], 32'h0);
    end
    // clock output: overrides gpio, peripherals see a constant 1
    for (int i = 0; i < 3; i++) begin
      wr(roff[i], rval[i]);
    end
    wr(SPF_OFF_DIR_A, 32'h0000_8000);
    wr(SPF_OFF_MUX, 32'h0000_0080);
    cpu_clock_output <= 1'b1;
    pad_in <= 4'h7;
    pads(4'h7, 4'h8, 4'h8);
    chk("periph", {28'h0, periph}, 32'hF);
    cpu_clock_output <= 1'b0;
    pads(4'h7, 4'h8, 4'h0);
    wr(SPF_OFF_MUX, 32'h0);
    step(3);
    chk("periph", {28'h0, periph}, 32'h8);
    end_sim();
  end
endmodule // spf_pin_mux_tb_top
`default_nettype wire
